// [design/pbc_brake.sv]
// What this block does
// - brake from software bit or pin
// - level select picks pin polarity
// - pin brake clears run, sets flag
// - flag readable, interrupt when enabled
// - after brake, outputs restore prior levels
// - flag cleared only by software
//
// Register access over APB and the register offsets were left to the implementer.
`timescale 1ns/1ns
module pbc_brake
  import pbc_pkg::*;
#(
  parameter int NCH = PBC_NCH
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // brake pin and pwm datapath
  input wire logic brake_pin_i,
  input wire logic [NCH-1:0] pwm_raw_i,
  input wire logic pwm_underflow_i,
  // outputs
  output logic [NCH-1:0] pwm_o,
  output logic pwm_counter_run_o,
  output logic brake_active_o,
  output logic irq_o
);
  pbc_apb_req_t req;
  pbc_state_t state;
  pbc_state_t next_state;
  logic [7:0] pwm_control_one;
  logic [7:0] next_pwm_control_one;
  logic [7:0] pwm_brake_control_reg;
  logic [7:0] next_pwm_brake_control_reg;
  logic [NCH-1:0] held_out;
  logic [NCH-1:0] next_held_out;
  logic [NCH-1:0] pwm_q;
  logic [NCH-1:0] next_pwm_q;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic pin_sync;
  logic pin_active;
  logic brake_req;
  logic wr_en;
  logic rd_en;
  logic brake_event_flag;
  logic irq_mask;
  logic flag_clr;
  logic mask_wr;
  logic pin_brake_set;
  logic brake_level_select;
  logic pin_enable;
  logic sw_brake;
  logic addr_ok;

  // decode one word address
  function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
    return a == r;
  endfunction

  // bundle the bus request
  always_comb begin
    req.sel = psel_i;
    req.enable = penable_i;
    req.write = pwrite_i;
    req.addr = paddr_i;
    req.wdata = pwdata_i;
  end

  pbc_sync u_sync (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .async_i(brake_pin_i),
    .sync_o(pin_sync)
  );

  assign brake_level_select = pwm_brake_control_reg[PBC_LVL_BIT];
  assign pin_enable = pwm_brake_control_reg[PBC_PINEN_BIT];
  assign sw_brake = pwm_brake_control_reg[PBC_SWBRK_BIT];
  assign pin_active = pin_enable & (brake_level_select ? pin_sync : ~pin_sync);
  assign brake_req = sw_brake | pin_active;
  // flag only from pin brake; is the software side's job
  assign pin_brake_set = pin_active;

  // access strobes, write in single-cycle access phase, read in setup phase
  assign wr_en = req.sel & req.enable & req.write;
  assign rd_en = req.sel & ~req.enable & ~req.write;
  assign addr_ok = hit(req.addr, PBC_ADDR_CTRL1) | hit(req.addr, PBC_ADDR_BRAKE)
    | hit(req.addr, PBC_ADDR_STAT) | hit(req.addr, PBC_ADDR_MASK)
    | hit(req.addr, PBC_ADDR_OUT);
  assign flag_clr = wr_en & hit(req.addr, PBC_ADDR_STAT) & req.wdata[PBC_FLAG_BIT];
  assign mask_wr = wr_en & hit(req.addr, PBC_ADDR_MASK);

  pbc_irq u_irq (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .set_i(pin_brake_set),
    .clr_i(flag_clr),
    .mask_wr_i(mask_wr),
    .mask_i(req.wdata[PBC_FLAG_BIT]),
    .flag_o(brake_event_flag),
    .mask_o(irq_mask),
    .irq_o(irq_o)
  );

  // control registers, hardware clears run on pin brake
  always_comb begin
    next_pwm_control_one = pwm_control_one;
    next_pwm_brake_control_reg = pwm_brake_control_reg;
    if (wr_en) begin
      if (hit(req.addr, PBC_ADDR_CTRL1)) begin
        next_pwm_control_one = req.wdata[7:0];
      end else if (hit(req.addr, PBC_ADDR_BRAKE)) begin
        next_pwm_brake_control_reg = req.wdata[7:0];
      end
    end
    if (pin_active) begin
      next_pwm_control_one[PBC_RUN_BIT] = 1'b0;
    end
  end

  // read data captured in setup phase
  always_comb begin
    next_rdata = PBC_ZERO;
    if (rd_en) begin
      if (hit(req.addr, PBC_ADDR_CTRL1)) begin
        next_rdata[7:0] = pwm_control_one;
      end else if (hit(req.addr, PBC_ADDR_BRAKE)) begin
        next_rdata[7:0] = pwm_brake_control_reg;
      end else if (hit(req.addr, PBC_ADDR_STAT)) begin
        next_rdata[PBC_FLAG_BIT] = brake_event_flag;
      end else if (hit(req.addr, PBC_ADDR_MASK)) begin
        next_rdata[PBC_FLAG_BIT] = irq_mask;
      end else if (hit(req.addr, PBC_ADDR_OUT)) begin
        next_rdata[NCH-1:0] = pwm_q;
        next_rdata[NCH] = brake_active_o;
      end
    end else begin
      next_rdata = rdata;
    end
  end

  // brake state machine and output selection
  always_comb begin
    next_state = state;
    next_held_out = held_out;
    next_pwm_q = pwm_q;
    case (state)
      PBC_IDLE: begin
        next_pwm_q = pwm_raw_i;
        if (brake_req) begin
          // remember levels just before the brake
          next_held_out = pwm_q;
          next_state = PBC_BRAKE;
        end
      end
      PBC_BRAKE: begin
        next_pwm_q = pwm_brake_control_reg[PBC_BLVL_LSB +: NCH];
        if (!brake_req) begin
          next_state = PBC_RELEASE;
        end
      end
      PBC_RELEASE: begin
        // restore prior levels until counter restarts cleanly
        next_pwm_q = held_out;
        if (brake_req) begin
          next_state = PBC_BRAKE;
        end else if (pwm_control_one[PBC_RUN_BIT] && pwm_underflow_i) begin
          next_state = PBC_IDLE;
        end
      end
      default: begin
        next_state = PBC_IDLE;
      end
    endcase
  end

  // registers
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= PBC_IDLE;
      pwm_control_one <= PBC_CTRL1_RST;
      pwm_brake_control_reg <= PBC_BRAKE_RST;
      held_out <= '0;
      pwm_q <= '0;
      rdata <= PBC_ZERO;
    end else begin
      state <= next_state;
      pwm_control_one <= next_pwm_control_one;
      pwm_brake_control_reg <= next_pwm_brake_control_reg;
      held_out <= next_held_out;
      pwm_q <= next_pwm_q;
      rdata <= next_rdata;
    end
  end

  assign pwm_o = pwm_q;
  assign pwm_counter_run_o = pwm_control_one[PBC_RUN_BIT];
  assign brake_active_o = (state == PBC_BRAKE);
  assign prdata_o = rdata;
  assign pready_o = 1'b1; // zero wait states
  assign pslverr_o = req.sel & req.enable & ~addr_ok;
endmodule // pbc_brake

// [design/pbc_pkg.sv]
package pbc_pkg;
  // register byte addresses
  localparam logic [11:0] PBC_ADDR_CTRL1 = 12'h000;
  localparam logic [11:0] PBC_ADDR_BRAKE = 12'h004;
  localparam logic [11:0] PBC_ADDR_STAT = 12'h008;
  localparam logic [11:0] PBC_ADDR_MASK = 12'h00c;
  localparam logic [11:0] PBC_ADDR_OUT = 12'h010;
  // field positions
  localparam int PBC_RUN_BIT = 7;
  localparam int PBC_SWBRK_BIT = 7;
  localparam int PBC_LVL_BIT = 6;
  localparam int PBC_PINEN_BIT = 4;
  localparam int PBC_BLVL_LSB = 0;
  localparam int PBC_FLAG_BIT = 0;
  localparam int PBC_NCH = 4;
  // reset values
  localparam logic [7:0] PBC_CTRL1_RST = 8'h00;
  localparam logic [7:0] PBC_BRAKE_RST = 8'h00;
  localparam logic [31:0] PBC_ZERO = 32'h0000_0000;

  // apb request bundle
  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } pbc_apb_req_t;

  // brake controller state
  typedef enum logic [1:0] {
    PBC_IDLE = 2'b00,
    PBC_BRAKE = 2'b01,
    PBC_RELEASE = 2'b10
  } pbc_state_t;
endpackage

// [design/pbc_sync.sv]
`timescale 1ns/1ns
// two flop synchroniser for the brake pin
module pbc_sync
  import pbc_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // async level in, synced out
  input wire logic async_i,
  output logic sync_o
);
  logic stage_one;
  logic stage_two;
  logic next_stage_one;
  logic next_stage_two;

  // next values
  always_comb begin
    next_stage_one = async_i;
    next_stage_two = stage_one;
  end

  // registers
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stage_one <= 1'b0;
      stage_two <= 1'b0;
    end else begin
      stage_one <= next_stage_one;
      stage_two <= next_stage_two;
    end
  end

  assign sync_o = stage_two;
endmodule // pbc_sync

// [design/pbc_irq.sv]
`timescale 1ns/1ns
// sticky brake event flag with mask and w1c
module pbc_irq
  import pbc_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // event and software access
  input wire logic set_i,
  input wire logic clr_i,
  input wire logic mask_wr_i,
  input wire logic mask_i,
  // state out
  output logic flag_o,
  output logic mask_o,
  output logic irq_o
);
  logic flag;
  logic mask;
  logic next_flag;
  logic next_mask;

  // flag set wins over clear, never cleared by hardware
  always_comb begin
    next_flag = flag;
    if (clr_i) begin
      next_flag = 1'b0;
    end
    if (set_i) begin
      next_flag = 1'b1;
    end
    next_mask = mask_wr_i ? mask_i : mask;
  end

  // registers
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flag <= 1'b0;
      mask <= 1'b0;
    end else begin
      flag <= next_flag;
      mask <= next_mask;
    end
  end

  assign flag_o = flag;
  assign mask_o = mask;
  assign irq_o = flag & mask;
endmodule // pbc_irq

// [bench/pbc_properties.sv]
`timescale 1ns/1ns
module pbc_properties
  import pbc_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // apb side
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // brake outputs
  input wire logic pwm_counter_run_o,
  input wire logic brake_active_o,
  input wire logic irq_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  // write landing this edge
  logic wr;
  logic rd_setup;
  logic wr_mask;
  logic wr_clear;
  logic wr_ctrl;
  assign wr = psel_i && penable_i && pwrite_i;
  // single-signal history for the past-value checks
  assign rd_setup = psel_i && !penable_i && !pwrite_i;
  assign wr_mask = wr && paddr_i == PBC_ADDR_MASK;
  assign wr_clear = wr && (paddr_i == PBC_ADDR_STAT || paddr_i == PBC_ADDR_MASK);
  assign wr_ctrl = wr && paddr_i == PBC_ADDR_CTRL1;
  a_ready_high: assert property (pready_o) else $error("pready low");
  a_err_unmapped: assert property (psel_i && penable_i && paddr_i > PBC_ADDR_OUT |-> pslverr_o)
    else $error("no error on unmapped access");
  a_err_mapped: assert property (psel_i && penable_i && paddr_i <= PBC_ADDR_OUT
    && paddr_i[1:0] == 2'h0 |-> !pslverr_o) else $error("error on mapped access");
  a_err_phase: assert property (pslverr_o |-> psel_i && penable_i) else $error("stray error");
  a_rdata_hold: assert property ($changed(prdata_o) |-> $past(rd_setup))
    else $error("read data moved without read");
  a_irq_rise: assert property ($rose(irq_o) |-> brake_active_o
    || $past(wr_mask)) else $error("irq rose without cause");
  a_irq_sticky: assert property ($fell(irq_o) |-> $past(wr_clear))
    else $error("irq fell alone");
  a_run_fall: assert property ($fell(pwm_counter_run_o) |-> brake_active_o
    || $past(wr_ctrl)) else $error("run fell without cause");
  c_brake: cover property ($rose(brake_active_o));
  c_irq: cover property ($rose(irq_o));
  c_err: cover property (pslverr_o);
endmodule // pbc_properties

bind pbc_brake pbc_properties i_chk (.ref_clk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i,
  .paddr_i, .prdata_o, .pready_o, .pslverr_o, .pwm_counter_run_o, .brake_active_o, .irq_o);

// [bench/pbc_pin_model.sv]
`timescale 1ns/1ns
// brake pin source; bench holds each level for many cycles
module pbc_pin_model (
  // request
  input wire logic assert_i,
  input wire logic active_high_i,
  // pin
  output logic pin_o
);
  assign pin_o = assert_i ? active_high_i : !active_high_i;
endmodule // pbc_pin_model

// [bench/pwm_brake_control_tb.sv]
`timescale 1ns/1ns
module pwm_brake_control_tb;
  import pbc_pkg::*;
  logic ref_clk_i = 0, rst_n_i = 0, psel = 0, pen = 0, pwr = 0, brk = 0, pol = 0, uf = 0;
  logic pin, ready, err, er, run, act, irq;
  logic [11:0] addr = 0;
  logic [31:0] wd = 0, rd, prdata;
  logic [3:0] raw = 0, lv, pre, pwm;
  int bad_count = 0, compares = 0;
  int model_held[$]; // levels seen just before each brake
  // clock
  always #5 ref_clk_i = ~ref_clk_i;
  pbc_pin_model i_pin (.assert_i(brk), .active_high_i(pol), .pin_o(pin));
  pbc_brake i_dut (.ref_clk_i, .rst_n_i, .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(addr), .pwdata_i(wd), .prdata_o(prdata), .pready_o(ready), .pslverr_o(err),
    .brake_pin_i(pin), .pwm_raw_i(raw), .pwm_underflow_i(uf), .pwm_o(pwm),
    .pwm_counter_run_o(run), .brake_active_o(act), .irq_o(irq));
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  // one apb transfer, request held until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    addr <= a;
    wd <= d;
    @(posedge ref_clk_i);
    pen <= 1'b1;
    @(posedge ref_clk_i);
    while (ready !== 1'b1) @(posedge ref_clk_i);
    rd = prdata;
    er = err;
    psel <= 1'b0;
    pen <= 1'b0;
    // idle edge so a following call never re-drives psel in this step
    @(posedge ref_clk_i);
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk_i);
  endtask
  task automatic final_report();
    if (bad_count == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // watchdog
  initial begin
    cyc(5000);
    bad_count++;
    final_report();
  end
  // main sequence
  initial begin
    void'($urandom(24));
    cyc(5);
    rst_n_i <= 1'b1;
    cyc(1);
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, 12'(i * 4), PBC_ZERO);
      chk("reset read", rd, PBC_ZERO);
      chk("slave error", 32'(er), 32'(i == 5));
    end
    for (int p = 0; p < 2; p++) begin
      pre = 4'($urandom);
      lv = 4'($urandom);
      raw <= pre;
      pol <= p[0];
      apb(1'b1, PBC_ADDR_MASK, 32'(p == 0));
      apb(1'b1, PBC_ADDR_CTRL1, 32'h80);
      apb(1'b1, PBC_ADDR_BRAKE, 32'(lv) | 32'h10 | (32'(p) << 6));
      model_held.push_back(int'(pre));
      brk <= 1'b1;
      cyc(6);
      chk("brake active", 32'(act), 32'h1);
      chk("run bit", 32'(run), 32'h0);
      chk("irq", 32'(irq), 32'(p == 0));
      chk("brake levels", 32'(pwm), 32'(lv));
      apb(1'b0, PBC_ADDR_STAT, PBC_ZERO);
      chk("flag", rd, 32'h1);
      brk <= 1'b0;
      raw <= ~pre;
      cyc(6);
      chk("restored", 32'(pwm), 32'(model_held.pop_front()));
      apb(1'b0, PBC_ADDR_STAT, PBC_ZERO);
      chk("flag kept", rd, 32'h1);
      apb(1'b1, PBC_ADDR_STAT, 32'h1);
      apb(1'b0, PBC_ADDR_STAT, PBC_ZERO);
      chk("flag cleared", rd, 32'h0);
      chk("irq cleared", 32'(irq), 32'h0);
      apb(1'b1, PBC_ADDR_CTRL1, 32'h80);
      uf <= 1'b1;
      cyc(1);
      uf <= 1'b0;
      cyc(3);
      chk("follow raw", 32'(pwm), {28'h0, ~pre});
      apb(1'b1, PBC_ADDR_BRAKE, PBC_ZERO);
    end
    // pin disabled, then software brake
    pol <= 1'b0;
    brk <= 1'b1;
    cyc(6);
    chk("pin ignored", 32'(act), 32'h0);
    brk <= 1'b0;
    lv = 4'($urandom);
    apb(1'b1, PBC_ADDR_BRAKE, 32'h80 | 32'(lv));
    cyc(3);
    chk("soft brake", 32'(act), 32'h1);
    chk("soft levels", 32'(pwm), 32'(lv));
    chk("soft run", 32'(run), 32'h1);
    apb(1'b0, PBC_ADDR_OUT, PBC_ZERO);
    chk("out readback", rd, 32'h10 | 32'(lv));
    final_report();
  end
endmodule // pwm_brake_control_tb
